// [pkg/msrc_consts.vh]
/*
 constants for the multi-source reset controller: flow codes, cause bits,
 timing counts and field widths.
 assumes a 50 MHz reference clock.
*/
`ifndef MSRC_CONSTS_VH
`define MSRC_CONSTS_VH

// clock period in ns
`define MSRC_CLK_PERIOD_NS      20
// soft release lag after hard release, in reference clock cycles
`define MSRC_SOFT_LAG_CYC       6'h10
// minimum length of a hard or soft pulse driven by the controller, cycles
`define MSRC_PULSE_CYC          6'h20
// counter width
`define MSRC_CNT_W              6
`define MSRC_CNT_ZERO           6'h00
`define MSRC_CNT_ONE            6'h01
// configuration field widths
`define MSRC_SRC_W              3
`define MSRC_CFG_W              17
`define MSRC_SRC_RST            3'h0
`define MSRC_CFG_RST            17'h0_0000
// cause bit positions in the status word
`define MSRC_CAUSE_W            8
`define MSRC_CAUSE_POR          0
`define MSRC_CAUSE_EXT_HARD     1
`define MSRC_CAUSE_EXT_SOFT     2
`define MSRC_CAUSE_WDOG         3
`define MSRC_CAUSE_TAP          4
`define MSRC_CAUSE_LINK         5
`define MSRC_CAUSE_SW_HARD      6
`define MSRC_CAUSE_SW_SOFT      7
`define MSRC_CAUSE_RST          8'h00
// flow codes
`define MSRC_FLOW_W             2
`define MSRC_FLOW_NONE          2'h0
`define MSRC_FLOW_SOFT          2'h1
`define MSRC_FLOW_HARD          2'h2
`define MSRC_FLOW_POR           2'h3

`endif

// [core/msrc_lag_counter.v]
/*
 down counter that holds an output high-active window for a loaded count.
 assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msrc_consts.vh"

module msrc_lag_counter (
   input  wire                    clk,        // reference clock
   input  wire                    rst_n,      // sync reset, active low
   input  wire                    load,       // load the count
   input  wire [`MSRC_CNT_W-1:0]  load_val,   // count to load
   output wire                    busy        // count not yet expired
);

   reg [`MSRC_CNT_W-1:0] cnt_q;               // remaining cycles

   // load wins over the decrement
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= `MSRC_CNT_ZERO;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (cnt_q != `MSRC_CNT_ZERO) begin
         cnt_q <= cnt_q - `MSRC_CNT_ONE;
      end
   end

   assign busy = (cnt_q != `MSRC_CNT_ZERO);

endmodule
`default_nettype wire

// [core/msrc_reset_ctrl.v]
/*
 multi-source reset controller: gathers eight reset sources, chooses the
 power-on, hard or soft flow, drives the open-drain hard and soft reset
 pins and the per-domain reset outputs, latches configuration at power-on
 and records the reset cause.
 assumes all inputs synchronous to clk; pins resolved outside from the
 output enables (enable low = pull low).
 limits: no synchroniser in front of the inputs; a source from
 another clock domain must be brought onto clk outside.
 one flow runs at a time; later requests other than an outside soft add to the record, but a hard request escalates a soft flow and power-on overrides any flow.
 cause record and configuration are cleared only by rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msrc_consts.vh"

module msrc_reset_ctrl (
   input  wire                    clk,                  // reference clock
   input  wire                    rst_n,                // sync reset, active low
   input  wire                    power_on_reset_in_n,  // power-on input, active low
   input  wire                    hard_reset_line_in,   // hard pin level
   output wire                    hard_reset_line_out,  // hard pin drive value
   output wire                    hard_reset_line_oe_n, // low = pulling pin low
   input  wire                    soft_reset_line_in,   // soft pin level
   output wire                    soft_reset_line_out,  // soft pin drive value
   output wire                    soft_reset_line_oe_n, // low = pulling pin low
   input  wire                    wdog_expired,         // watchdog count at zero
   input  wire                    wdog_enable,          // watchdog enabled
   input  wire                    tap_host_reset,       // tap host reset command
   input  wire                    tap_scan_active,      // extest/clamp/highz loaded
   input  wire                    tap_scan_drives_soft, // instruction drives soft pin
   input  wire                    link_hard_req,        // serial link hard request
   input  wire                    reset_control_reg_wr, // write to control reg
   input  wire                    reset_control_reg_hard, // write data: hard bit
   input  wire                    reset_control_reg_soft, // write data: soft bit
   input  wire [`MSRC_SRC_W-1:0]  config_source_select, // source select pins
   input  wire [`MSRC_CFG_W-1:0]  config_pins,          // configuration pins
   output reg  [`MSRC_SRC_W-1:0]  cfg_src_q,            // latched source select
   output reg  [`MSRC_CFG_W-1:0]  cfg_word_q,           // latched config word
   output reg                     cfg_valid_q,          // config word captured
   output reg                     pll_reset_q,          // pll reset, active high
   output reg                     periph_bus_reset_q,   // peripheral bus modules
   output reg                     core_reset_q,         // extended cores
   output reg                     timer_reset_q,        // timers, perf monitor
   output reg                     fabric_reset_q,       // fabric registers
   output reg                     wdog_event_q,         // watchdog reset event
   output reg  [`MSRC_CAUSE_W-1:0] reset_status_q,      // latest reset causes
   output reg  [`MSRC_FLOW_W-1:0] flow_q                // active flow code
);

   ////////////////////////////////////////////////////////////////////////////
   // local state
   // idle waits for a request, hold runs the pulse counter, lag
   // keeps only the soft pin, porin waits for the power-on input
   // to rise; power-on overrides any state.

   localparam [1:0] ST_IDLE  = 2'h0;          // no reset driven
   localparam [1:0] ST_HOLD  = 2'h1;          // hard and/or soft driven
   localparam [1:0] ST_LAG   = 2'h2;          // hard released, soft held
   localparam [1:0] ST_PORIN = 2'h3;          // power-on input asserted

   reg  [1:0]              state_q;           // sequencer state
   reg  [1:0]              state_d;           // next state
   reg                     hard_drv_q;        // pulling hard pin
   reg                     hard_drv_d;
   reg                     soft_drv_q;        // pulling soft pin
   reg                     soft_drv_d;
   reg  [`MSRC_FLOW_W-1:0] flow_d;            // next flow
   reg                     cnt_load;          // load the shared counter
   reg  [`MSRC_CNT_W-1:0]  cnt_val;           // value for the counter
   wire                    cnt_busy;          // counter running

   ////////////////////////////////////////////////////////////////////////////
   // source decode
   // every source is a level taken on each edge; a one-cycle
   // pulse (register write, watchdog expiry) starts a flow.
   // a pin that we pull ourselves is masked so that our own
   // drive is never read back as an outside request.

   wire por_act   = ~power_on_reset_in_n;
   // hard pin low while we do not pull it means an outside request
   wire ext_hard  = ~hard_reset_line_in & ~hard_drv_q;
   // outside soft only counts while no reset is being driven; the
   // enable covers our own pulls and a scan instruction's pull
   wire ext_soft  = ~soft_reset_line_in & soft_reset_line_oe_n
                    & (state_q == ST_IDLE);
   wire wdog_hit  = wdog_expired & wdog_enable;
   wire sw_hard   = reset_control_reg_wr & reset_control_reg_hard;
   wire sw_soft   = reset_control_reg_wr & reset_control_reg_soft;
   wire any_hard  = ext_hard | wdog_hit | link_hard_req | sw_hard;
   wire any_soft  = ext_soft | tap_host_reset | sw_soft;

   // causes seen this cycle, one bit per source
   // (bit order from the cause positions in the header)
   wire [`MSRC_CAUSE_W-1:0] cause_now;
   assign cause_now[`MSRC_CAUSE_POR]      = por_act;
   assign cause_now[`MSRC_CAUSE_EXT_HARD] = ext_hard;
   assign cause_now[`MSRC_CAUSE_EXT_SOFT] = ext_soft;
   assign cause_now[`MSRC_CAUSE_WDOG]     = wdog_hit;
   assign cause_now[`MSRC_CAUSE_TAP]      = tap_host_reset;
   assign cause_now[`MSRC_CAUSE_LINK]     = link_hard_req;
   assign cause_now[`MSRC_CAUSE_SW_HARD]  = sw_hard;
   assign cause_now[`MSRC_CAUSE_SW_SOFT]  = sw_soft;

   // severity order: power-on over hard over soft
   // only idle and a running soft flow act on it
   wire [`MSRC_FLOW_W-1:0] req_flow =
      por_act  ? `MSRC_FLOW_POR  :
      any_hard ? `MSRC_FLOW_HARD :
      any_soft ? `MSRC_FLOW_SOFT : `MSRC_FLOW_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // shared counter: pulse length, then soft lag
   // one counter serves both: pulse and lag never overlap

   msrc_lag_counter u_cnt (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (cnt_load),
      .load_val (cnt_val),
      .busy     (cnt_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   // hard flow, in clk edges from the request edge:
   //   edge 0    request seen, both pins pulled
   //   edge 33   pulse count empty, hard pin let go
   //   edge 49   lag count empty, soft pin let go
   // a soft flow lets its pin go at edge 33, with no lag.
   // power-on holds both pins while the input is low,
   // then runs the same pulse and lag once it rises.
   // the lag load is one short: the soft drive register
   // follows the empty count one edge later.


   always @* begin
      state_d    = state_q;
      hard_drv_d = hard_drv_q;
      soft_drv_d = soft_drv_q;
      flow_d     = flow_q;
      cnt_load   = 1'b0;
      cnt_val    = `MSRC_PULSE_CYC;
      if (por_act) begin
         // power-on input overrides everything
         // the pulse counter loads only once the input rises
         state_d    = ST_PORIN;
         hard_drv_d = 1'b1;
         soft_drv_d = 1'b1;
         flow_d     = `MSRC_FLOW_POR;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // idle: start hard or soft flow
               // hard first, so a mixed request runs hard
               if (req_flow == `MSRC_FLOW_HARD) begin
                  state_d    = ST_HOLD;
                  hard_drv_d = 1'b1;
                  soft_drv_d = 1'b1;
                  flow_d     = `MSRC_FLOW_HARD;
                  cnt_load   = 1'b1;
               end else if (req_flow == `MSRC_FLOW_SOFT) begin
                  state_d    = ST_HOLD;
                  soft_drv_d = 1'b1;
                  flow_d     = `MSRC_FLOW_SOFT;
                  cnt_load   = 1'b1;
               end
            end
            ST_PORIN: begin
               // input released: hold hard for one pulse, then lag
               // configuration stops latching from here on
               state_d  = ST_HOLD;
               cnt_load = 1'b1;
            end
            ST_HOLD: begin
               // soft flow escalates to hard on a hard request
               // and restarts the pulse; power-on is caught above
               if (flow_q == `MSRC_FLOW_SOFT && any_hard) begin
                  hard_drv_d = 1'b1;
                  flow_d     = `MSRC_FLOW_HARD;
                  cnt_load   = 1'b1;
               end else if (!cnt_busy) begin
                  if (hard_drv_q) begin
                     // hard released, soft kept for the lag
                     state_d    = ST_LAG;
                     hard_drv_d = 1'b0;
                     cnt_load   = 1'b1;
                     cnt_val    = `MSRC_SOFT_LAG_CYC - `MSRC_CNT_ONE;
                  end else begin
                     // soft flow done: no lag, back to idle
                     state_d    = ST_IDLE;
                     soft_drv_d = 1'b0;
                     flow_d     = `MSRC_FLOW_NONE;
                  end
               end
            end
            ST_LAG: begin
               // soft stays low until the lag expires
               if (!cnt_busy) begin
                  state_d    = ST_IDLE;
                  soft_drv_d = 1'b0;
                  flow_d     = `MSRC_FLOW_NONE;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer registers
   // reset leaves idle with both pin drives cleared; a scan instruction can still pull the soft pin

   always @(posedge clk) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         hard_drv_q <= 1'b0;
         soft_drv_q <= 1'b0;
         flow_q     <= `MSRC_FLOW_NONE;
      end else begin
         state_q    <= state_d;
         hard_drv_q <= hard_drv_d;
         soft_drv_q <= soft_drv_d;
         flow_q     <= flow_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain pins: only ever pull low
   // the drive value is tied low and only the enables move,
   // so a pin is never driven high against the pull-ups
   // or against another agent that pulls it too.

   assign hard_reset_line_out  = 1'b0;
   assign hard_reset_line_oe_n = ~hard_drv_q;
   assign soft_reset_line_out  = 1'b0;
   // soft held while hard held; scan instruction may also drive it
   assign soft_reset_line_oe_n = ~(soft_drv_q | hard_drv_q
                                  | (tap_scan_active & tap_scan_drives_soft));

   ////////////////////////////////////////////////////////////////////////////
   // configuration capture, power-on only
   // runs on every edge of the power-on window, so the value
   // kept is the one present at its last edge.

   always @(posedge clk) begin
      if (!rst_n) begin
         cfg_src_q   <= `MSRC_SRC_RST;
         cfg_word_q  <= `MSRC_CFG_RST;
         cfg_valid_q <= 1'b0;
      end else if (por_act) begin
         // hard and soft flows never reach here
         cfg_src_q   <= config_source_select;
         cfg_word_q  <= config_pins;
         cfg_valid_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // domain reset outputs
   // taken from the next flow, so they rise on the same edge
   // as the pin enables and the flow code.
   // timers and fabric registers keep state through soft flows;
   // scan instructions reset peripherals and cores without a
   // flow of their own.

   wire flow_on   = (flow_d != `MSRC_FLOW_NONE);
   wire flow_hard = (flow_d == `MSRC_FLOW_HARD) | (flow_d == `MSRC_FLOW_POR);

   always @(posedge clk) begin
      if (!rst_n) begin
         pll_reset_q        <= 1'b0;
         periph_bus_reset_q <= 1'b0;
         core_reset_q       <= 1'b0;
         timer_reset_q      <= 1'b0;
         fabric_reset_q     <= 1'b0;
      end else begin
         pll_reset_q        <= por_act;
         periph_bus_reset_q <= flow_on | tap_scan_active;
         core_reset_q       <= flow_on | tap_scan_active;
         timer_reset_q      <= flow_hard;
         fabric_reset_q     <= flow_hard;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog event and cause status
   // the record is replaced at start or escalation and grows
   // while a flow runs; it outlives the flow so that software
   // can read the cause once out of reset.

   wire flow_start = (flow_q == `MSRC_FLOW_NONE) & flow_on;
   // a flow ending is not an escalation
   wire escalate   = (flow_d != flow_q) & (flow_q != `MSRC_FLOW_NONE)
                     & (flow_d != `MSRC_FLOW_NONE);

   always @(posedge clk) begin
      if (!rst_n) begin
         wdog_event_q   <= 1'b0;
         reset_status_q <= `MSRC_CAUSE_RST;
      end else begin
         wdog_event_q <= wdog_hit;
         if (flow_start | escalate) begin
            // new reset: replace the record with this cycle's causes
            reset_status_q <= cause_now;
         end else if (flow_on) begin
            // sources joining a running reset are added
            reset_status_q <= reset_status_q | cause_now;
         end
      end
   end

endmodule
`default_nettype wire

// [tb/msrc_reset_ctrl_chk.sv]
/*
 port checker for the multi-source reset controller, bound to its top.
 assumes one clock, synchronous active-low reset, pins resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msrc_consts.vh"

module msrc_chk (
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    power_on_reset_in_n,
   input wire logic                    hard_reset_line_in,
   input wire logic                    hard_reset_line_oe_n,
   input wire logic                    soft_reset_line_oe_n,
   input wire logic                    wdog_expired,
   input wire logic                    wdog_enable,
   input wire logic                    link_hard_req,
   input wire logic                    reset_control_reg_wr,
   input wire logic                    reset_control_reg_hard,
   input wire logic                    reset_control_reg_soft,
   input wire logic [`MSRC_CFG_W-1:0]  config_pins,
   input wire logic [`MSRC_CFG_W-1:0]  cfg_word_q,
   input wire logic                    pll_reset_q,
   input wire logic                    periph_bus_reset_q,
   input wire logic                    core_reset_q,
   input wire logic                    timer_reset_q,
   input wire logic                    wdog_event_q,
   input wire logic [`MSRC_CAUSE_W-1:0] reset_status_q,
   input wire logic [`MSRC_FLOW_W-1:0] flow_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////
   wire       hard_src;   // any hard-class request this cycle
   logic [5:0] lag_q;     // cycles since hard pin release, soft held
   assign hard_src = link_hard_req | (wdog_expired & wdog_enable) | !hard_reset_line_in
                     | (reset_control_reg_wr & reset_control_reg_hard);

   // count the gap between hard and soft release
   always @(posedge clk) begin
      if (!rst_n)
         lag_q <= 6'h00;
      else if (!hard_reset_line_oe_n)
         lag_q <= 6'h01;
      else if (lag_q != 6'h00 && !soft_reset_line_oe_n)
         lag_q <= lag_q + 6'h01;
      else
         lag_q <= 6'h00;
   end

   ////////////////////////////////////////////////////////////////
   chk_por_capture: assert property (
      !power_on_reset_in_n |=> cfg_word_q == $past(config_pins) && pll_reset_q
      && core_reset_q && flow_q == `MSRC_FLOW_POR && !hard_reset_line_oe_n)
      else $error("power-on did not capture config or drive resets");
   chk_cfg_frozen: assert property (
      power_on_reset_in_n |=> $stable(cfg_word_q))
      else $error("config word changed outside power-on");
   chk_hard_start: assert property (
      hard_src && power_on_reset_in_n && flow_q == `MSRC_FLOW_NONE |=>
      flow_q == `MSRC_FLOW_HARD && !hard_reset_line_oe_n && timer_reset_q && core_reset_q)
      else $error("hard request did not start hard flow");
   chk_soft_start: assert property (
      reset_control_reg_wr && reset_control_reg_soft && !hard_src && power_on_reset_in_n
      && flow_q == `MSRC_FLOW_NONE |=> flow_q == `MSRC_FLOW_SOFT && !soft_reset_line_oe_n
      && hard_reset_line_oe_n && !timer_reset_q && !pll_reset_q && $stable(cfg_word_q))
      else $error("soft write did not start a clean soft flow");
   chk_wdog_event: assert property (
      1'b1 |=> wdog_event_q == $past(wdog_expired && wdog_enable))
      else $error("watchdog event does not follow enabled expiry");
   chk_soft_with_hard: assert property (
      !hard_reset_line_oe_n |-> !soft_reset_line_oe_n)
      else $error("soft pin released while hard pin driven");
   chk_hard_pin_flow: assert property (
      !hard_reset_line_oe_n |-> flow_q inside {`MSRC_FLOW_HARD, `MSRC_FLOW_POR})
      else $error("hard pin driven outside hard or power-on flow");
   chk_periph_every_flow: assert property (
      flow_q != `MSRC_FLOW_NONE |-> periph_bus_reset_q && core_reset_q)
      else $error("peripheral or core reset missing in a flow");
   chk_busy_ignore: assert property (
      flow_q != `MSRC_FLOW_NONE |=> !$rose(reset_status_q[`MSRC_CAUSE_EXT_SOFT]))
      else $error("external soft taken while busy");
   chk_soft_lag: assert property (
      lag_q != 6'h00 && soft_reset_line_oe_n |-> lag_q == 6'h11)
      else $error("soft release lag after hard release is wrong");
endmodule

bind msrc_reset_ctrl msrc_chk i_msrc_chk (.clk, .rst_n, .power_on_reset_in_n,
   .hard_reset_line_in, .hard_reset_line_oe_n, .soft_reset_line_oe_n, .wdog_expired,
   .wdog_enable, .link_hard_req, .reset_control_reg_wr, .reset_control_reg_hard,
   .reset_control_reg_soft, .config_pins, .cfg_word_q, .pll_reset_q, .periph_bus_reset_q,
   .core_reset_q, .timer_reset_q, .wdog_event_q, .reset_status_q, .flow_q);
`default_nettype wire

// [tb/msrc_board_model.sv]
/*
 board side of the reset pins: pull-ups on both open-drain lines and a
 power-on supervisor. assumes the bench asks for power-on and external pulls.
*/
`timescale 1ns/1ps
`default_nettype none

module msrc_board_model (
   input  wire logic clk,
   input  wire logic por_req,       // supervisor asked to hold power-on
   input  wire logic ext_hard_pull, // external agent pulls hard pin
   input  wire logic ext_soft_pull, // external agent pulls soft pin
   input  wire logic hard_oe_n,     // device pulls hard pin when low
   input  wire logic soft_oe_n,     // device pulls soft pin when low
   output wire logic por_n,         // power-on input, active low
   output wire logic hard_line,     // resolved hard pin
   output wire logic soft_line      // resolved soft pin
);
   logic [5:0] por_cnt_q;  // cycles since the request dropped

   // stretch power-on so it always stands at least 32 cycles
   always @(posedge clk) begin
      if (por_req)
         por_cnt_q <= 6'h00;
      else if (por_cnt_q != 6'h3f)
         por_cnt_q <= por_cnt_q + 6'h01;
   end
   assign por_n = !por_req && por_cnt_q >= 6'h20;

   // wired-and with pull-up: any party may pull low
   assign hard_line = hard_oe_n & !ext_hard_pull;
   assign soft_line = soft_oe_n & !ext_soft_pull;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
 self-checking bench for the reset controller with a board model.
 assumes 50 MHz clock, inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msrc_consts.vh"

module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, por_req = 1'b1, wdog_enable = 1'b1;
   logic        scan_act = 1'b0, scan_soft = 1'b0;
   logic [7:0]  src = 8'h00;          // one bit per cause position
   logic [2:0]  cfg_sel = 3'h5;
   logic [16:0] cfg_pins = 17'h1_2345;
   int          fail_count = 0, checks_done = 0;
   wire         por_n, hard_line, soft_line, hard_oe_n, soft_oe_n;
   wire         cfg_valid, pll, periph, core, timer, wdog_event, fabric, hard_out, soft_out;
   wire [2:0]   cfg_src_q;
   wire [16:0]  cfg_word_q;
   wire [7:0]   status;
   wire [1:0]   flow_q;

   always #10 clk = ~clk;

   msrc_board_model i_msrc_board_model (.clk(clk), .por_req(por_req),
      .ext_hard_pull(src[1]), .ext_soft_pull(src[2]), .hard_oe_n(hard_oe_n),
      .soft_oe_n(soft_oe_n), .por_n(por_n), .hard_line(hard_line), .soft_line(soft_line));

   msrc_reset_ctrl i_msrc_reset_ctrl (.clk(clk), .rst_n(rst_n), .power_on_reset_in_n(por_n),
      .hard_reset_line_in(hard_line), .hard_reset_line_out(hard_out),
      .hard_reset_line_oe_n(hard_oe_n), .soft_reset_line_in(soft_line),
      .soft_reset_line_out(soft_out), .soft_reset_line_oe_n(soft_oe_n),
      .wdog_expired(src[3]), .wdog_enable(wdog_enable), .tap_host_reset(src[4]),
      .tap_scan_active(scan_act), .tap_scan_drives_soft(scan_soft), .link_hard_req(src[5]),
      .reset_control_reg_wr(src[6] | src[7]), .reset_control_reg_hard(src[6]),
      .reset_control_reg_soft(src[7]), .config_source_select(cfg_sel), .config_pins(cfg_pins),
      .cfg_src_q(cfg_src_q), .cfg_word_q(cfg_word_q), .cfg_valid_q(cfg_valid),
      .pll_reset_q(pll), .periph_bus_reset_q(periph), .core_reset_q(core),
      .timer_reset_q(timer), .fabric_reset_q(fabric), .wdog_event_q(wdog_event),
      .reset_status_q(status), .flow_q(flow_q));

   ////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (fail_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // bounded wait for the flow to return to idle
   task automatic wait_idle;
      int n;
      n = 0;
      while (flow_q !== `MSRC_FLOW_NONE && n < 300) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      if (n >= 300) begin
         fail_count++;
         finish_test;
      end
   endtask

   // one-cycle request on the chosen sources
   task automatic pulse(input logic [7:0] s);
      @(negedge clk);
      src = s;
      @(negedge clk);
      src = 8'h00;
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic s_power_on;
      @(negedge clk);
      check(flow_q, `MSRC_FLOW_POR);
      check({hard_out, soft_out}, 2'h0);
      check({hard_oe_n, soft_oe_n, pll, core, periph, timer}, 6'h0f);
      check(status, 8'h01);
      check({cfg_src_q, cfg_word_q}, {3'h5, 17'h1_2345});
      cfg_sel = 3'h2;
      cfg_pins = 17'h0_abcd;
      @(negedge clk);
      check({cfg_src_q, cfg_word_q, cfg_valid}, {3'h2, 17'h0_abcd, 1'b1});
      por_req = 1'b0;
      wait_idle;
      cfg_sel = 3'h7;
      cfg_pins = 17'h1_ffff;
   endtask

   // start a flow and judge pins, domain resets, cause and config
   task automatic run_flow(input logic [7:0] s);
      logic [16:0] w;
      logic        hard;
      w = cfg_word_q;
      hard = (s & 8'h6a) != 8'h00;
      pulse(s);
      check(flow_q, hard ? `MSRC_FLOW_HARD : `MSRC_FLOW_SOFT);
      check(status, s);
      check({hard_oe_n, soft_oe_n}, {!hard, 1'b0});
      check({timer, fabric, core, periph, pll, wdog_event}, {hard, hard, 3'b110, s[3]});
      wait_idle;
      check({status, cfg_src_q, cfg_word_q}, {s, 3'h2, w});
   endtask

   task automatic s_misc;
      wdog_enable = 1'b0;
      pulse(8'h08);
      check({flow_q, wdog_event}, 3'h0);
      wdog_enable = 1'b1;
      pulse(8'h20);
      pulse(8'h84);
      check({flow_q, status}, {`MSRC_FLOW_HARD, 8'ha0});
      wait_idle;
      check(flow_q, `MSRC_FLOW_NONE);
      scan_act = 1'b1;
      scan_soft = 1'b1;
      @(negedge clk);
      check({hard_oe_n, soft_oe_n, core, periph, timer}, 5'h16);
      scan_soft = 1'b0;
      @(negedge clk);
      check(soft_oe_n, 1'b1);
      scan_act = 1'b0;
      pulse(8'h20);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      check({flow_q, status, hard_oe_n, soft_oe_n}, {2'h0, 8'h00, 2'h3});
      rst_n = 1'b1;
      pulse(8'h80);
      check({flow_q, status}, {`MSRC_FLOW_SOFT, 8'h80});
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] s;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      s_power_on;
      s = 8'h02;
      repeat (7) begin
         run_flow(s);
         s = s << 1;
      end
      run_flow(8'ha0);
      run_flow(8'h14);
      s_misc;
      finish_test;
   end
endmodule
`default_nettype wire
